// *** verilog/motor_protection_pkg.sv ***
// Constants shared by the motor protection control block.
// Assumes a 32-bit APB master and a single 125 MHz system clock.
package motor_protection_pkg;
   // -------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_TRIGGER_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SOURCE_SELECT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_FAULT_STATE = 8'h10;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int BIT_OC_HW_EN = 0;
   localparam int BIT_OC_SW_EN = 1;
   localparam int BIT_LIMIT_EN = 2;
   localparam int BIT_SENSE_EN = 3;
   localparam int BIT_STALL_EN = 4;
   localparam int BIT_CBC_EN = 5;
   localparam int BIT_OC_SRC = 6;
   // Status/mask bits.
   localparam int EV_OC = 0;
   localparam int EV_SENSE = 1;
   localparam int EV_LIMIT = 2;
   localparam int EV_STALL = 3;
   localparam int EV_SW = 4;
   localparam int EV_W = 5;
   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [7:0] RST_TRIGGER_CONTROL = 8'h00;
   localparam logic [7:0] RST_SOURCE_SELECT = 8'h00;
   localparam logic [7:0] SOURCE_SELECT_MASK = 8'h7f;
   localparam logic [EV_W-1:0] RST_EVENTS = 5'h00;
   typedef enum logic [1:0] {REL_IDLE, REL_LOW_SEEN} release_state_t;
endpackage

// *** verilog/motor_protection_control.sv ***
// Trigger enables, over-current source select and latch/cycle-by-cycle
// protection with an APB register slave and a level interrupt.
// Assumes all inputs synchronous to CLK_SYS_IN.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Over-current hardware trigger fires protection only while its enable is 1.
// - Fired over-current protection latches; released by enable high, low, high.
// - Source select 0 picks current-sense fault, 1 comparator rising edge.
// - Cycle-by-cycle enable replaces latched shutdown by per-period protection.
// - Stall compare trigger enable gates the stall detection hardware trigger.
// - Cycle mode blocks PWM on fault, restores next period, reblocks if persisting.
module motor_protection_control
   import motor_protection_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic CURRENT_SENSE_FAULT_IN,
   input wire logic FIRST_COMPARATOR_IN,
   input wire logic CURRENT_LIMIT_IN,
   input wire logic CAPTURE_TIMER_COMPARE_STALL_IN,
   input wire logic SW_OVERCURRENT_TRIGGER_IN,
   input wire logic PWM_PERIOD_START_IN,
   output logic OVERCURRENT_PROTECTION_OUT,
   output logic PWM_BLOCK_OUT,
   output logic FAULT_TRIGGER_OUT,
   output logic IRQ_OUT
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   // Every flip-flop of the block lives in this one record, so the reset
   // branch and the next-state logic cannot drift apart.
   typedef struct packed {
      logic [7:0] trig_ctrl;
      logic [7:0] src_sel;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic cmp_prev;
      logic oc_latched;
      logic cbc_block;
      release_state_t rel;
      logic fault_trig;
      logic [31:0] rdata;
      logic rd_wait;
      logic pwm_block;
      logic irq;
   } state_t;

   state_t cur_r;
   state_t cur_nxt;

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic oc_event;
   logic oc_trigger;
   logic [EV_W-1:0] events;
   logic access;
   logic sense_trig;
   logic limit_trig;
   logic stall_trig;
   logic sw_trig;

   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   // Writes finish in their first access cycle; reads take one wait state so
   // that the returned word comes straight from a flip-flop.
   assign access = PSEL_IN && PENABLE_IN;
   assign wr_en = access && PWRITE_IN;
   assign rd_en = access && !PWRITE_IN;

   always_comb begin
      case (PADDR_IN)
         ADDR_TRIGGER_CONTROL: begin
            addr_ok = 1'b1;
         end
         ADDR_SOURCE_SELECT: begin
            addr_ok = 1'b1;
         end
         ADDR_IRQ_STATUS: begin
            addr_ok = 1'b1;
         end
         ADDR_IRQ_MASK: begin
            addr_ok = 1'b1;
         end
         ADDR_FAULT_STATE: begin
            addr_ok = 1'b1;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Fault sources
   // -------------------------------------------------------------
   always_comb begin
      if (cur_r.src_sel[BIT_OC_SRC]) begin
         oc_event = FIRST_COMPARATOR_IN && !cur_r.cmp_prev;
      end else begin
         oc_event = CURRENT_SENSE_FAULT_IN;
      end
      oc_trigger = oc_event && cur_r.trig_ctrl[BIT_OC_HW_EN];
      events = '0;
      events[EV_OC] = oc_trigger;
      events[EV_SENSE] = sense_trig;
      events[EV_LIMIT] = limit_trig;
      events[EV_STALL] = stall_trig;
      events[EV_SW] = sw_trig;
   end

   motor_protection_gate #(.W(1)) sense_gate (
      .source_in(CURRENT_SENSE_FAULT_IN),
      .enable_in(cur_r.trig_ctrl[BIT_SENSE_EN]),
      .trigger_out(sense_trig)
   );
   motor_protection_gate #(.W(1)) limit_gate (
      .source_in(CURRENT_LIMIT_IN),
      .enable_in(cur_r.trig_ctrl[BIT_LIMIT_EN]),
      .trigger_out(limit_trig)
   );
   motor_protection_gate #(.W(1)) stall_gate (
      .source_in(CAPTURE_TIMER_COMPARE_STALL_IN),
      .enable_in(cur_r.trig_ctrl[BIT_STALL_EN]),
      .trigger_out(stall_trig)
   );
   motor_protection_gate #(.W(1)) sw_gate (
      .source_in(SW_OVERCURRENT_TRIGGER_IN),
      .enable_in(cur_r.trig_ctrl[BIT_OC_SW_EN]),
      .trigger_out(sw_trig)
   );

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.cmp_prev = FIRST_COMPARATOR_IN;
      // A read is answered in the cycle after its first access cycle.
      cur_nxt.rd_wait = rd_en && !cur_r.rd_wait;

      // Register writes.
      if (wr_en) begin
         case (PADDR_IN)
            ADDR_TRIGGER_CONTROL: begin
               cur_nxt.trig_ctrl = PWDATA_IN[7:0];
            end
            ADDR_SOURCE_SELECT: begin
               cur_nxt.src_sel = PWDATA_IN[7:0] & SOURCE_SELECT_MASK;
            end
            ADDR_IRQ_STATUS: begin
               cur_nxt.status = cur_r.status & ~PWDATA_IN[EV_W-1:0];
            end
            ADDR_IRQ_MASK: begin
               cur_nxt.mask = PWDATA_IN[EV_W-1:0];
            end
            default: begin
               cur_nxt.status = cur_nxt.status;
            end
         endcase
      end
      // Set wins over a clear in the same cycle.
      cur_nxt.status = cur_nxt.status | events;

      // release sequence watches the enable going high, low, high
      case (cur_r.rel)
         REL_IDLE: begin
            if (cur_r.oc_latched && !cur_nxt.trig_ctrl[BIT_OC_HW_EN]) begin
               cur_nxt.rel = REL_LOW_SEEN;
            end
         end
         REL_LOW_SEEN: begin
            if (cur_nxt.trig_ctrl[BIT_OC_HW_EN]) begin
               cur_nxt.oc_latched = 1'b0;
               cur_nxt.rel = REL_IDLE;
            end
         end
         default: cur_nxt.rel = REL_IDLE;
      endcase

      if (cur_r.src_sel[BIT_CBC_EN]) begin
         // restore at period start, reblock while fault persists
         if (oc_trigger) begin
            cur_nxt.cbc_block = 1'b1;
         end else if (PWM_PERIOD_START_IN) begin
            cur_nxt.cbc_block = 1'b0;
         end
      end else begin
         cur_nxt.cbc_block = 1'b0;
         if (oc_trigger) begin
            cur_nxt.oc_latched = 1'b1;
            cur_nxt.rel = REL_IDLE;
         end
      end

      cur_nxt.fault_trig = |events[EV_SW:EV_SENSE];
      // either form of protection stops the PWM
      cur_nxt.pwm_block = cur_nxt.oc_latched || cur_nxt.cbc_block;
      cur_nxt.irq = |(cur_nxt.status & cur_nxt.mask);

      // The read word is captured once and then stands through the wait state.
      if (rd_en && !cur_r.rd_wait) begin
         case (PADDR_IN)
            ADDR_TRIGGER_CONTROL: begin
               cur_nxt.rdata = {24'h000000, cur_r.trig_ctrl};
            end
            ADDR_SOURCE_SELECT: begin
               cur_nxt.rdata = {24'h000000, cur_r.src_sel};
            end
            ADDR_IRQ_STATUS: begin
               cur_nxt.rdata = {27'h0, cur_r.status};
            end
            ADDR_IRQ_MASK: begin
               cur_nxt.rdata = {27'h0, cur_r.mask};
            end
            ADDR_FAULT_STATE: begin
               cur_nxt.rdata = {29'h0, cur_r.fault_trig, cur_r.cbc_block, cur_r.oc_latched};
            end
            default: begin
               cur_nxt.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         cur_r <= '{
            trig_ctrl: RST_TRIGGER_CONTROL,
            src_sel: RST_SOURCE_SELECT,
            status: RST_EVENTS,
            mask: RST_EVENTS,
            cmp_prev: 1'b0,
            oc_latched: 1'b0,
            cbc_block: 1'b0,
            rel: REL_IDLE,
            fault_trig: 1'b0,
            rdata: 32'h00000000,
            rd_wait: 1'b0,
            pwm_block: 1'b0,
            irq: 1'b0
         };
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Handshake outputs are combinational so that writes need no wait state.
   always_comb begin
      PREADY_OUT = access && (PWRITE_IN || cur_r.rd_wait);
      PSLVERR_OUT = access && (PWRITE_IN || cur_r.rd_wait) && !addr_ok;
   end

   assign PRDATA_OUT = cur_r.rdata;
   assign OVERCURRENT_PROTECTION_OUT = cur_r.oc_latched;
   assign PWM_BLOCK_OUT = cur_r.pwm_block;
   assign FAULT_TRIGGER_OUT = cur_r.fault_trig;
   assign IRQ_OUT = cur_r.irq;
endmodule

// Enable gate of one protection trigger source; a source is passed on only
// while its enable bit is set.
module motor_protection_gate #(
   parameter int W = 1
) (
   input wire logic [W-1:0] source_in,
   input wire logic enable_in,
   output logic [W-1:0] trigger_out
);
   assign trigger_out = source_in & {W{enable_in}};
endmodule
`default_nettype wire

// *** sim/motor_protection_assertions.sv ***
// Port checker of motor_protection_control, attached by the bind below.
// Assumes register writes land on an APB edge with pready high.
`timescale 1ns/100ps
`default_nettype none
module motor_protection_assertions
   import motor_protection_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic PREADY_OUT,
   input wire logic CURRENT_SENSE_FAULT_IN,
   input wire logic OVERCURRENT_PROTECTION_OUT,
   input wire logic PWM_BLOCK_OUT,
   input wire logic FAULT_TRIGGER_OUT
);
   logic [7:0] tc_r, ss_r;
   wire logic wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
   wire logic hw = tc_r[BIT_OC_HW_EN] && !ss_r[BIT_CBC_EN];
   wire logic sense = CURRENT_SENSE_FAULT_IN && !ss_r[BIT_OC_SRC];
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) {tc_r, ss_r} <= 16'h0000;
      else if (wr && PADDR_IN == ADDR_TRIGGER_CONTROL) tc_r <= PWDATA_IN[7:0];
      else if (wr && PADDR_IN == ADDR_SOURCE_SELECT) ss_r <= PWDATA_IN[7:0];
   end
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   // Four quiet bus cycles rule out a release that is still in flight.
   sequence s_held; !PSEL_IN [*4] ##0 (OVERCURRENT_PROTECTION_OUT && hw); endsequence
   sequence s_low_quiet; OVERCURRENT_PROTECTION_OUT && !tc_r[BIT_OC_HW_EN] && !wr; endsequence
   property p_gate; $rose(OVERCURRENT_PROTECTION_OUT) |-> $past(tc_r[BIT_OC_HW_EN]); endproperty
   property p_keep; s_low_quiet |=> OVERCURRENT_PROTECTION_OUT; endproperty
   property p_hold; s_held |=> OVERCURRENT_PROTECTION_OUT; endproperty
   property p_fire; hw && sense |-> ##[1:3] OVERCURRENT_PROTECTION_OUT; endproperty
   property p_cbc; tc_r[BIT_OC_HW_EN] && ss_r[BIT_CBC_EN] && sense |-> ##[1:3] PWM_BLOCK_OUT; endproperty
   property p_quiet; tc_r[4:0] == 5'h00 && $past(tc_r[4:0]) == 5'h00 |-> !FAULT_TRIGGER_OUT; endproperty
   a_gate: assert property (p_gate) else $error("ungated protection");
   a_hold: assert property (p_hold) else $error("latch lost");
   a_keep: assert property (p_keep) else $error("released while enable low");
   a_fire: assert property (p_fire) else $error("no protection");
   a_cbc: assert property (p_cbc) else $error("no cycle block");
   a_quiet: assert property (p_quiet) else $error("trigger while off");
endmodule
bind motor_protection_control motor_protection_assertions chk_i (.*);
`default_nettype wire

// *** sim/motor_drive_model.sv ***
// Far-side model making the PWM period start pulse.
// Assumes the bench drives the fault lines in its place.
`timescale 1ns/100ps
`default_nettype none
module motor_drive_model (
   input wire logic clk_in,
   input wire logic rst_in,
   output logic period_out
);
   logic [3:0] cnt_r;
   always_ff @(posedge clk_in) cnt_r <= rst_in ? 4'h0 : cnt_r + 4'h1;
   assign period_out = (cnt_r == 4'hf);
endmodule
`default_nettype wire

// *** sim/test_motor_protection_control.sv ***
// Bench of motor_protection_control: APB calls and fault stimulus.
// Assumes the bound checker and the period model.
`timescale 1ns/100ps
`default_nettype none
module test_motor_protection_control
   import motor_protection_pkg::*;
;
   logic CLK_SYS_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, v;
   logic [7:0] PADDR_IN = 8'h00;
   logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, q;
   logic PREADY_OUT, PSLVERR_OUT, PWM_PERIOD_START_IN, OVERCURRENT_PROTECTION_OUT;
   logic PWM_BLOCK_OUT, FAULT_TRIGGER_OUT, IRQ_OUT;
   logic [4:0] f = 5'h00;
   int mismatches = 0, comparisons = 0, cyc = 0;
   wire logic CURRENT_SENSE_FAULT_IN = f[0], FIRST_COMPARATOR_IN = f[1];
   wire logic CURRENT_LIMIT_IN = f[2], SW_OVERCURRENT_TRIGGER_IN = f[3];
   wire logic CAPTURE_TIMER_COMPARE_STALL_IN = f[4];
   motor_protection_control uut (.*);
   motor_drive_model far (.clk_in(CLK_SYS_IN), .rst_in(RST_IN), .period_out(PWM_PERIOD_START_IN));
   initial forever #4 CLK_SYS_IN = ~CLK_SYS_IN;
   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_IN) {PSEL_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= {1'b1, w, a, d};
      @(posedge CLK_SYS_IN) PENABLE_IN <= 1;
      do @(posedge CLK_SYS_IN); while (PREADY_OUT !== 1'b1);
      q = PRDATA_OUT;
      v = PSLVERR_OUT;
      {PSEL_IN, PENABLE_IN} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic ck(input string n, input logic e, ref logic s);
      repeat (4) @(posedge CLK_SYS_IN);
      chk(n, e, s);
   endtask
   always @(posedge CLK_SYS_IN) begin
      if (++cyc == 3000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(posedge CLK_SYS_IN);
      RST_IN <= 0;
      rd(ADDR_TRIGGER_CONTROL, 0);
      bus(1, ADDR_SOURCE_SELECT, 32'hff);
      chk("write error", 0, v);
      rd(ADDR_SOURCE_SELECT, SOURCE_SELECT_MASK);
      bus(1, 8'h3c, 32'hff);
      chk("unmapped error", 1, v);
      bus(1, ADDR_SOURCE_SELECT, 0);
      rd(ADDR_TRIGGER_CONTROL, 0);
      f <= 5'h01;
      ck("off", 0, OVERCURRENT_PROTECTION_OUT);
      bus(1, ADDR_TRIGGER_CONTROL, 1);
      ck("fired", 1, OVERCURRENT_PROTECTION_OUT);
      f <= 5'h00;
      bus(1, ADDR_TRIGGER_CONTROL, 0);
      ck("latched", 1, OVERCURRENT_PROTECTION_OUT);
      bus(1, ADDR_TRIGGER_CONTROL, 1);
      ck("released", 0, OVERCURRENT_PROTECTION_OUT);
      bus(0, ADDR_IRQ_STATUS, 0);
      chk("event", 1, q[EV_OC]);
      bus(1, ADDR_IRQ_MASK, 32'h1f);
      ck("irq", 1, IRQ_OUT);
      bus(1, ADDR_IRQ_MASK, 0);
      ck("irq mask", 0, IRQ_OUT);
      bus(1, ADDR_IRQ_STATUS, 32'h1f);
      rd(ADDR_IRQ_STATUS, 0);
      bus(1, ADDR_SOURCE_SELECT, 32'h40);
      f <= 5'h01;
      ck("sense off", 0, OVERCURRENT_PROTECTION_OUT);
      f <= 5'h02;
      ck("edge", 1, OVERCURRENT_PROTECTION_OUT);
      f <= 5'h00;
      bus(1, ADDR_TRIGGER_CONTROL, 0);
      bus(1, ADDR_TRIGGER_CONTROL, 1);
      ck("edge released", 0, OVERCURRENT_PROTECTION_OUT);
      bus(1, ADDR_SOURCE_SELECT, 32'h20);
      f <= 5'h01;
      ck("cycle block", 1, PWM_BLOCK_OUT);
      ck("no latch", 0, OVERCURRENT_PROTECTION_OUT);
      repeat (16) @(posedge CLK_SYS_IN);
      ck("persist", 1, PWM_BLOCK_OUT);
      f <= 5'h00;
      repeat (20) @(posedge CLK_SYS_IN);
      ck("restored", 0, PWM_BLOCK_OUT);
      bus(1, ADDR_SOURCE_SELECT, 32'h02);
      bus(1, ADDR_TRIGGER_CONTROL, 0);
      for (int i = 2; i < 5; i++) begin
         f <= (i == 3) ? 5'h01 : (5'h01 << i);
         ck("gated", 0, FAULT_TRIGGER_OUT);
         bus(1, ADDR_TRIGGER_CONTROL, 32'h1 << i);
         ck("source", 1, FAULT_TRIGGER_OUT);
         f <= 5'h00;
         bus(1, ADDR_TRIGGER_CONTROL, 0);
      end
      complete_run();
   end
endmodule
`default_nettype wire
